//--- dv/hvs_panel_model.sv
// front-panel operator and remote host model for the supervisor bench
`timescale 1ns/1ps
module hvs_panel_model (
  input wire logic clk_in,
  output logic [3:0] btn_out,
  output logic [4:0] cmd_out,
  output logic loop_out,
  output logic ack_out
);
  initial begin
    btn_out = 4'h0;
    cmd_out = 5'h00;
    loop_out = 1'b1;
    ack_out = 1'b0;
  end
  // held four cycles so the two-flop sync cannot miss a press
  task automatic press(input int b);
    @(posedge clk_in) btn_out[b] <= 1'b1;
    repeat (4) @(posedge clk_in);
    btn_out[b] <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task automatic command(input int i);
    @(posedge clk_in) cmd_out[i] <= 1'b1;
    @(posedge clk_in) cmd_out <= 5'h00;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic set_loop(input logic closed);
    @(posedge clk_in) loop_out <= closed;
    repeat (6) @(posedge clk_in);
    #1;
  endtask
  // operator only confirms once the loop is really closed
  task automatic acknowledge();
    @(posedge clk_in) ack_out <= loop_out;
    repeat (4) @(posedge clk_in);
    ack_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
endmodule

//--- dv/tb_top.sv
// self-checking bench for the high-voltage output supervisor
`timescale 1ns/1ps
module tb_top;
  import hvs_pkg::*;
  logic clk, rst, f_rail, f_link, f_temp, imm, cwr, cnt, awr, ramp_done, loop, ack, r_on, r_off;
  logic local_ind, panel_acc, gen, ramp_en, arc_recovery_ramp_rate, err, loop_err, flag, edit_i, show, menu_o, cnt_o;
  logic [3:0] btn;
  logic [4:0] cmd;
  logic [ARC_CNT_W-1:0] allowed, count, allowed_o;
  logic [VAL_W-1:0] current_setpoint, output_current;
  hvs_iface_type iface;
  int num_errors, comparisons, n;
  int unsigned seed;
  hvs_panel_model pm (.clk_in(clk), .btn_out(btn), .cmd_out(cmd), .loop_out(loop), .ack_out(ack));
  hvs_supervisor #(.TICK_DIV(4), .SHOW_TICKS(3), .WINDOW_TICKS(20), .WAIT_TICKS(2)) uut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .IF_CMD_IN(cmd), .MENU_EXIT_BUTTON_IN(btn[0]),
    .SELECT_BUTTON_IN(btn[1]), .OUTPUT_TOGGLE_BUTTON_IN(btn[2]), .ENCODER_PUSH_IN(btn[3]),
    .RAIL_FAULT_IN(f_rail), .LINK_DROP_IN(f_link), .TEMP_FAULT_IN(f_temp),
    .SAFETY_LOOP_INPUT_IN(loop), .LOOP_ACK_IN(ack), .REMOTE_ON_IN(r_on), .REMOTE_OFF_IN(r_off),
    .IMMEDIATE_SHUTDOWN_MODE_IN(imm), .ARC_COUNTING_WR_IN(cwr), .ARC_COUNTING_IN(cnt),
    .ALLOWED_ARC_COUNT_WR_IN(awr), .ALLOWED_ARC_COUNT_IN(allowed), .CURRENT_SETPOINT_IN(current_setpoint),
    .OUTPUT_CURRENT_IN(output_current), .RAMP_DONE_IN(ramp_done), .LOCAL_INDICATOR_OUT(local_ind),
    .IFACE_OUT(iface), .PANEL_ACCEPT_OUT(panel_acc), .GEN_ENABLE_OUT(gen), .RAMP_ENABLE_OUT(ramp_en),
    .ARC_RECOVERY_RAMP_RATE_SEL_OUT(arc_recovery_ramp_rate), .ERROR_OUT(err), .LOOP_ERROR_OUT(loop_err),
    .ARC_LIMIT_EXCEEDED_FLAG_OUT(flag), .ARC_COUNT_OUT(count), .EDIT_CURRENT_OUT(edit_i),
    .SHOW_SETPOINTS_OUT(show), .MENU_OPEN_OUT(menu_o), .ARC_COUNTING_OUT(cnt_o),
    .ALLOWED_ARC_COUNT_OUT(allowed_o));
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait on gen (sel 0) or show (sel 1); running out ends the run
  task automatic wait_for(input int sel, input logic e);
    for (int k = 0; k < 60; k++) begin
      cyc(1);
      if ((sel ? show : gen) === e) return;
    end
    check("wait", sel ? show : gen, e);
    test_done();
  endtask
  // arc threshold worked out as 2*output_current >= 3*current_setpoint, so one below must not trip
  // fresh random setpoint each time, up to 43015 so 3*current_setpoint can need 17 bits
  task automatic arc(input logic hit);
    int unsigned s;
    s = 16 + xs() % 43000;
    @(posedge clk) begin
      current_setpoint <= VAL_W'(s);
      output_current <= VAL_W'((3 * s + 1) / 2 - (hit ? 0 : 1));
    end
    @(posedge clk) output_current <= '0;
    cyc(3);
  endtask
  // one-cycle host on or off pulse
  task automatic host_cmd(input logic on);
    @(posedge clk) {r_on, r_off} <= {on, !on};
    @(posedge clk) {r_on, r_off} <= 2'b00;
    cyc(2);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst, ramp_done} = 2'b11;
    {f_rail, f_link, f_temp, imm, cwr, cnt, awr, r_on, r_off} = '0;
    allowed = 8'h00;
    output_current = 16'h0000;
    seed = 42095;
    current_setpoint = VAL_W'(16 + xs() % 1000);
    num_errors = 0;
    comparisons = 0;
    cyc(8);
    rst <= 1'b0;
    cyc(3);
    check("local", local_ind, 1);
    check("iface", iface, IF_NONE);
    check("counting", cnt_o, 0);
    check("allowed", allowed_o, 16'h0001);
    check("edit", edit_i, 0);
    check("show", show, 1);
    $display("test reset done");
    pm.press(1);
    check("edit", edit_i, 1);
    pm.press(1);
    check("edit", edit_i, 0);
    pm.press(0);
    check("menu", menu_o, 1);
    pm.press(0);
    check("menu", menu_o, 0);
    check("panel", panel_acc, 1);
    $display("test panel done");
    pm.press(2);
    check("gen", gen, 1);
    check("show", show, 0);
    pm.press(3);
    check("show", show, 1);
    wait_for(1, 0);
    check("show", show, 0);
    $display("test display done");
    arc(0);
    check("gen", gen, 1);
    arc(1);
    check("gen", gen, 0);
    check("arc_recovery_ramp_rate", arc_recovery_ramp_rate, 0);
    wait_for(0, 1);
    check("arc_recovery_ramp_rate", arc_recovery_ramp_rate, 1);
    n = 1 + xs() % 4;
    @(posedge clk) {cwr, cnt, awr, allowed} <= {3'b111, 8'(n)};
    @(posedge clk) {cwr, awr} <= 2'b00;
    cyc(2);
    check("counting", cnt_o, 1);
    check("allowed", allowed_o, 16'(n));
    for (int a = 1; a <= n + 1; a++) begin
      arc(1);
      check("gen", gen, a <= n);
      check("flag", flag, a == n + 1);
      if (a <= n) check("count", count, 16'(a));
    end
    pm.press(2);
    cyc(100);
    check("count", count, 0);
    check("flag", flag, 0);
    imm <= 1'b1;
    arc(1);
    check("gen", gen, 0);
    cyc(30);
    check("gen", gen, 0);
    imm <= 1'b0;
    $display("test arcs done");
    for (int f = 0; f < 3; f++) begin
      pm.press(2);
      wait_for(0, 1);
      @(posedge clk) {f_temp, f_link, f_rail} <= 3'b001 << f;
      cyc(4);
      check("gen", gen, 0);
      check("error", err, 1);
      pm.press(2);
      check("gen", gen, 0);
      @(posedge clk) {f_temp, f_link, f_rail} <= 3'b000;
      cyc(4);
      check("error", err, 0);
    end
    $display("test faults done");
    pm.set_loop(0);
    check("loop error", loop_err, 1);
    pm.press(2);
    check("gen", gen, 0);
    pm.set_loop(1);
    check("loop error", loop_err, 1);
    pm.acknowledge();
    check("loop error", loop_err, 0);
    pm.press(2);
    check("gen", gen, 1);
    $display("test loop done");
    @(posedge clk) ramp_done <= 1'b0;
    pm.press(2);
    check("show", show, 0);
    @(posedge clk) ramp_done <= 1'b1;
    cyc(4);
    check("show", show, 0);
    wait_for(1, 1);
    check("gen", gen, 0);
    $display("test ramp-down done");
    for (int i = 0; i < 5; i++) begin
      pm.command(i);
      check("local", local_ind, 0);
      check("iface", iface, i < 4 ? 16'(i + 1) : 16'(IF_NONE));
      if (i == 0) begin
        pm.press(2);
        check("gen", gen, 0);
        host_cmd(1'b1);
        check("gen", gen, 1);
        host_cmd(1'b0);
        check("gen", gen, 0);
      end
      pm.press(0);
      check("local", local_ind, 1);
    end
    $display("test remote done");
    test_done();
  end
endmodule

//--- shared/hvs_pkg.sv
// shared constants and types for the high-voltage output supervisor
package hvs_pkg;
  localparam int VAL_W = 16;
  localparam int ARC_CNT_W = 8;
  localparam int CLK_HZ = 200_000_000;
  localparam int SHOW_TIME_MS = 4000;
  localparam int ARC_WINDOW_MS = 10000;
  localparam int ARC_RECOVERY_DELAY_MS = 1000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int LINE_MIN_VAC = 95;
  localparam int AIR_MAX_DEGC = 50;
  localparam int ARC_NUM_X2 = 3;
  localparam int VRAMP_PERMILLE = 200;
  localparam int IRAMP_PERMILLE = 100_000;
  localparam int ARC_RECOVERY_RAMP_RATE_PERMILLE = 5000;
  localparam logic [ARC_CNT_W-1:0] ARC_COUNT_RST = 8'h01;
  localparam logic ARC_COUNTING_RST = 1'b0;
  typedef enum logic [2:0] {
    IF_NONE,
    IF_USB,
    IF_ETH,
    IF_CAN,
    IF_SER
  } hvs_iface_type;
  typedef enum logic [1:0] {
    CTL_LOCAL,
    CTL_REMOTE
  } hvs_ctl_type;
endpackage

//--- verilog/hvs_supervisor.sv
// supervisory control of the high-voltage output: control origin, faults, arcs, display
`timescale 1ns/1ps
module hvs_supervisor #(
  parameter int TICK_DIV = hvs_pkg::TICK_CYCLES,
  parameter int SHOW_TICKS = hvs_pkg::SHOW_TIME_MS * 1000 / hvs_pkg::TICK_US,
  parameter int WINDOW_TICKS = hvs_pkg::ARC_WINDOW_MS * 1000 / hvs_pkg::TICK_US,
  parameter int WAIT_TICKS = hvs_pkg::ARC_RECOVERY_DELAY_MS * 1000 / hvs_pkg::TICK_US
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [4:0] IF_CMD_IN,
  input wire logic MENU_EXIT_BUTTON_IN,
  input wire logic SELECT_BUTTON_IN,
  input wire logic OUTPUT_TOGGLE_BUTTON_IN,
  input wire logic ENCODER_PUSH_IN,
  input wire logic RAIL_FAULT_IN,
  input wire logic LINK_DROP_IN,
  input wire logic TEMP_FAULT_IN,
  input wire logic SAFETY_LOOP_INPUT_IN,
  input wire logic LOOP_ACK_IN,
  input wire logic REMOTE_ON_IN,
  input wire logic REMOTE_OFF_IN,
  input wire logic IMMEDIATE_SHUTDOWN_MODE_IN,
  input wire logic ARC_COUNTING_WR_IN,
  input wire logic ARC_COUNTING_IN,
  input wire logic ALLOWED_ARC_COUNT_WR_IN,
  input wire logic [hvs_pkg::ARC_CNT_W-1:0] ALLOWED_ARC_COUNT_IN,
  input wire logic [hvs_pkg::VAL_W-1:0] CURRENT_SETPOINT_IN,
  input wire logic [hvs_pkg::VAL_W-1:0] OUTPUT_CURRENT_IN,
  input wire logic RAMP_DONE_IN,
  output logic LOCAL_INDICATOR_OUT,
  output hvs_pkg::hvs_iface_type IFACE_OUT,
  output logic PANEL_ACCEPT_OUT,
  output logic GEN_ENABLE_OUT,
  output logic RAMP_ENABLE_OUT,
  output logic ARC_RECOVERY_RAMP_RATE_SEL_OUT,
  output logic ERROR_OUT,
  output logic LOOP_ERROR_OUT,
  output logic ARC_LIMIT_EXCEEDED_FLAG_OUT,
  output logic [hvs_pkg::ARC_CNT_W-1:0] ARC_COUNT_OUT,
  output logic EDIT_CURRENT_OUT,
  output logic SHOW_SETPOINTS_OUT,
  output logic MENU_OPEN_OUT,
  output logic ARC_COUNTING_OUT,
  output logic [hvs_pkg::ARC_CNT_W-1:0] ALLOWED_ARC_COUNT_OUT
);
  import hvs_pkg::*;

  // button and sensor inputs come from pins: two-stage sync, then edge detect on buttons and ack; sensors used as levels
  localparam int NSYNC = 10;
  // loop bit resets to closed so leaving reset does not latch a false loop error
  localparam logic [NSYNC-1:0] SYNC_RST = 10'h100;
  logic [NSYNC-1:0] raw, s1_q, s2_q, s3_q;
  assign raw = {LOOP_ACK_IN, SAFETY_LOOP_INPUT_IN, TEMP_FAULT_IN, LINK_DROP_IN, RAIL_FAULT_IN,
                ENCODER_PUSH_IN, OUTPUT_TOGGLE_BUTTON_IN, SELECT_BUTTON_IN, MENU_EXIT_BUTTON_IN, 1'b0};
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic menu_p, sel_p, tog_p, enc_p, ack_p, rail, link, temp, loop_closed;
  assign menu_p = s2_q[1] & ~s3_q[1];
  assign sel_p = s2_q[2] & ~s3_q[2];
  assign tog_p = s2_q[3] & ~s3_q[3];
  assign enc_p = s2_q[4] & ~s3_q[4];
  assign rail = s2_q[5];
  assign link = s2_q[6];
  assign temp = s2_q[7];
  assign loop_closed = s2_q[8];
  assign ack_p = s2_q[9] & ~s3_q[9];

  // millisecond tick from divider
  logic [31:0] div_q;
  logic tick;
  assign tick = (div_q == 32'(TICK_DIV - 1));
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) div_q <= '0;
    else div_q <= tick ? '0 : div_q + 32'h0000_0001;
  end

  // control origin
  hvs_ctl_type ctl_q;
  hvs_iface_type iface_q;
  logic any_cmd;
  assign any_cmd = |IF_CMD_IN;
  function automatic hvs_iface_type pick_iface(input logic [4:0] c);
    if (c[0]) return IF_USB;
    else if (c[1]) return IF_ETH;
    else if (c[2]) return IF_CAN;
    else if (c[3]) return IF_SER;
    else return IF_NONE;
  endfunction
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ctl_q <= CTL_LOCAL;
      iface_q <= IF_NONE;
    end else if (any_cmd) begin
      ctl_q <= CTL_REMOTE;
      iface_q <= pick_iface(IF_CMD_IN);
    end else if (menu_p && ctl_q == CTL_REMOTE) begin
      ctl_q <= CTL_LOCAL;
    end
  end
  logic local_st;
  assign local_st = (ctl_q == CTL_LOCAL);
  assign LOCAL_INDICATOR_OUT = local_st;
  assign IFACE_OUT = local_st ? IF_NONE : iface_q;
  assign PANEL_ACCEPT_OUT = local_st;

  // arc configuration, factory defaults at reset
  logic counting_q;
  logic [ARC_CNT_W-1:0] allowed_q;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      counting_q <= ARC_COUNTING_RST;
      allowed_q <= ARC_COUNT_RST;
    end else begin
      if (ARC_COUNTING_WR_IN) counting_q <= ARC_COUNTING_IN;
      if (ALLOWED_ARC_COUNT_WR_IN) allowed_q <= ALLOWED_ARC_COUNT_IN;
    end
  end
  assign ARC_COUNTING_OUT = counting_q;
  assign ALLOWED_ARC_COUNT_OUT = allowed_q;

  // arc detect: 2*output_current >= 3*current_setpoint, widened to avoid overflow
  logic arc;
  assign arc = ({1'b0, OUTPUT_CURRENT_IN, 1'b0} >= (VAL_W + 2)'(ARC_NUM_X2) * {2'b00, CURRENT_SETPOINT_IN});

  // faults; loop error is latched until closed and acknowledged
  logic loop_err_q, fault;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) loop_err_q <= 1'b0;
    else if (!loop_closed) loop_err_q <= 1'b1;
    else if (ack_p) loop_err_q <= 1'b0;
  end
  assign fault = rail | link | temp;
  assign ERROR_OUT = fault | loop_err_q;
  assign LOOP_ERROR_OUT = loop_err_q;

  // output state machine
  typedef enum logic [2:0] {
    OUT_OFF,
    OUT_ON,
    OUT_RAMP_DOWN,
    OUT_ARC_RECOVERY_DELAY,
    OUT_ARC_RECOVERY_RAMP_RATE
  } hvs_out_type;
  hvs_out_type st_q;
  logic [31:0] wait_q, win_q;
  logic [ARC_CNT_W-1:0] arcs_q;
  logic flag_q, want_on, want_off, arc_trip;
  assign want_on = (local_st & tog_p) | (~local_st & REMOTE_ON_IN);
  // a panel toggle may switch off even under remote control
  assign want_off = tog_p | (~local_st & REMOTE_OFF_IN);
  assign arc_trip = counting_q && (arcs_q >= allowed_q);
  logic start_ok;
  assign start_ok = want_on && !fault && !loop_err_q && loop_closed;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_q <= OUT_OFF;
      wait_q <= '0;
    end else begin
      case (st_q)
        OUT_OFF: begin
          if (start_ok) st_q <= OUT_ON;
        end
        OUT_ON: begin
          if (fault || loop_err_q) st_q <= OUT_OFF;
          else if (arc && IMMEDIATE_SHUTDOWN_MODE_IN) st_q <= OUT_OFF;
          else if (arc && arc_trip) st_q <= OUT_OFF;
          else if (arc && !counting_q) begin
            st_q <= OUT_ARC_RECOVERY_DELAY;
            wait_q <= '0;
          end else if (want_off) st_q <= OUT_RAMP_DOWN;
        end
        OUT_RAMP_DOWN: begin
          if (fault || loop_err_q || RAMP_DONE_IN) st_q <= OUT_OFF;
        end
        OUT_ARC_RECOVERY_DELAY: begin
          if (fault || loop_err_q || want_off) st_q <= OUT_OFF;
          else if (tick) begin
            if (wait_q >= 32'(WAIT_TICKS - 1)) st_q <= OUT_ARC_RECOVERY_RAMP_RATE;
            else wait_q <= wait_q + 32'h0000_0001;
          end
        end
        OUT_ARC_RECOVERY_RAMP_RATE: begin
          if (fault || loop_err_q) st_q <= OUT_OFF;
          else if (want_off) st_q <= OUT_RAMP_DOWN;
          else if (RAMP_DONE_IN) st_q <= OUT_ON;
        end
        default: st_q <= OUT_OFF;
      endcase
    end
  end
  // generation stays on during arc counting; regulator restores at once
  assign GEN_ENABLE_OUT = (st_q == OUT_ON) || (st_q == OUT_RAMP_DOWN) || (st_q == OUT_ARC_RECOVERY_RAMP_RATE);
  assign RAMP_ENABLE_OUT = (st_q != OUT_OFF);
  assign ARC_RECOVERY_RAMP_RATE_SEL_OUT = (st_q == OUT_ARC_RECOVERY_RAMP_RATE);

  // arc counter and window
  logic win_end;
  assign win_end = tick && (win_q >= 32'(WINDOW_TICKS - 1));
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      arcs_q <= '0;
      win_q <= '0;
    end else if (!counting_q) begin
      arcs_q <= '0;
      win_q <= '0;
    end else begin
      // window keeps time in arc cycles too; an arc on expiry opens the next window
      if (tick) win_q <= win_end ? '0 : win_q + 32'h0000_0001;
      if (win_end) arcs_q <= (st_q == OUT_ON && arc) ? 8'h01 : 8'h00;
      else if (st_q == OUT_ON && arc) arcs_q <= arcs_q + 8'h01;
    end
  end
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) flag_q <= 1'b0;
    else if (st_q == OUT_ON && arc && arc_trip && !IMMEDIATE_SHUTDOWN_MODE_IN) flag_q <= 1'b1;
    else if (want_on) flag_q <= 1'b0;
  end
  assign ARC_COUNT_OUT = arcs_q;
  assign ARC_LIMIT_EXCEEDED_FLAG_OUT = flag_q;

  // panel: edit select, menu
  logic edit_i_q, menu_q;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) edit_i_q <= 1'b0;
    else if (local_st && sel_p) edit_i_q <= ~edit_i_q;
  end
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) menu_q <= 1'b0;
    else if (menu_p && local_st) menu_q <= ~menu_q;
  end
  assign EDIT_CURRENT_OUT = edit_i_q;
  assign MENU_OPEN_OUT = menu_q;

  // display: setpoints while off, timed view while on or in arc recovery, measured values in ramp-down
  logic show_q;
  logic [31:0] show_cnt_q;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      show_q <= 1'b1;
      show_cnt_q <= '0;
    end else if (st_q == OUT_ON || st_q == OUT_ARC_RECOVERY_RAMP_RATE || st_q == OUT_ARC_RECOVERY_DELAY) begin
      if (enc_p && !menu_q) begin
        show_q <= ~show_q;
        show_cnt_q <= '0;
      end else if (show_q && tick) begin
        if (show_cnt_q >= 32'(SHOW_TICKS - 1)) begin
          show_q <= 1'b0;
          show_cnt_q <= '0;
        end else show_cnt_q <= show_cnt_q + 32'h0000_0001;
      end
    end else if (st_q == OUT_RAMP_DOWN) begin
      show_q <= 1'b0;
      show_cnt_q <= '0;
    end else if (start_ok) begin
      // generation starting: measured values from the first cycle
      show_q <= 1'b0;
      show_cnt_q <= '0;
    end else if (!show_q && tick) begin
      if (show_cnt_q >= 32'(SHOW_TICKS - 1)) show_q <= 1'b1;
      else show_cnt_q <= show_cnt_q + 32'h0000_0001;
    end
  end
  assign SHOW_SETPOINTS_OUT = show_q;

  chk_loop_blocks_on: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (st_q == OUT_OFF && !loop_closed) |=> st_q == OUT_OFF)
    else $error("switch-on with open loop");
  chk_loop_latch: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (!loop_closed) |=> loop_err_q)
    else $error("open loop not latched");
  chk_fault_stops: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (fault && st_q == OUT_ON) |=> !GEN_ENABLE_OUT)
    else $error("fault did not stop output");
  chk_kill_arc: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (st_q == OUT_ON && arc && IMMEDIATE_SHUTDOWN_MODE_IN) |=> st_q == OUT_OFF)
    else $error("immediate mode arc not off");
  sequence s_arc_plain;
    st_q == OUT_ON && arc && !counting_q && !IMMEDIATE_SHUTDOWN_MODE_IN && !fault && !loop_err_q;
  endsequence
  chk_arc_recovery_delay: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_arc_plain |=> st_q == OUT_ARC_RECOVERY_DELAY && !GEN_ENABLE_OUT)
    else $error("arc_recovery_delay not entered");
  chk_cmd_remote: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    any_cmd |=> !LOCAL_INDICATOR_OUT)
    else $error("command did not enter remote");
  chk_cmd_iface: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (|IF_CMD_IN[3:0]) |=> IFACE_OUT != IF_NONE)
    else $error("interface not shown");
  chk_menu_local: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (menu_p && !any_cmd) |=> LOCAL_INDICATOR_OUT)
    else $error("menu did not return local");
  chk_arc_limit: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (st_q == OUT_ON && arc && arc_trip && !IMMEDIATE_SHUTDOWN_MODE_IN) |=> flag_q && st_q == OUT_OFF)
    else $error("arc limit not handled");
endmodule
